// file: logic/sgl_pkg.sv
// package: address map, field positions and reset values of the sgmii port
package sgl_pkg;

  // ****************************************
  // direct management offsets
  // ****************************************
  localparam logic [15:0] INDIRECT_ADDRESS_OFS = 16'h7200;
  localparam logic [15:0] INDIRECT_DATA_OFS = 16'h7206;

  // ****************************************
  // indirect register addresses
  // ****************************************
  localparam logic [31:0] PCS_CONTROL_ADR = 32'h001F0000;
  localparam logic [31:0] AUTONEG_ADVERTISE_ADR = 32'h001F0004;
  localparam logic [31:0] LINK_STATUS_ADR = 32'h001F8002;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTL_RESET_BIT = 15;
  localparam int CTL_SPEED_LSB_BIT = 13;
  localparam int CTL_AN_ENABLE_BIT = 12;
  localparam int CTL_DUPLEX_BIT = 8;
  localparam int CTL_SPEED_MSB_BIT = 6;

  // ****************************************
  // status register fields
  // ****************************************
  localparam int STS_AN_DONE_BIT = 0;
  localparam int STS_LINK_BIT = 1;
  localparam int STS_SPEED_LSB = 2;
  localparam int STS_DUPLEX_BIT = 4;

  // ****************************************
  // speed encoding and reset values
  // ****************************************
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [15:0] PCS_CONTROL_RESET = 16'h1140;
  localparam logic [15:0] AUTONEG_ADVERTISE_RESET = 16'h0000;
  localparam logic [31:0] INDIRECT_ADDRESS_RESET = 32'h00000000;
  localparam logic [15:0] CODE_WORD_MANDATORY = 16'h0001;

endpackage

// file: logic/sgl_hold_reg.sv
// module: 16-bit register returned to RESET_VALUE only at power-up or by an interface reset
`timescale 1ns/1ps
`default_nettype none

module sgl_hold_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  // clock and power-up reset
  input wire logic clock,
  input wire logic rst_b,
  // control
  input wire logic restore,
  input wire logic load,
  input wire logic [15:0] loadValue,
  // value
  output logic [15:0] value
);

  logic [15:0] valueReg;

  // restore beats a load in the same cycle: a reset request must stick
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      valueReg <= RESET_VALUE;
    end else if (restore) begin
      valueReg <= RESET_VALUE;
    end else if (load) begin
      valueReg <= loadValue;
    end
  end

  assign value = valueReg;

endmodule

`default_nettype wire

// file: logic/sgl_sgmii_port.sv
// module: port-7 sgmii indirect register window and pcs link configuration
//
// Functional notes
// - sgmii registers reachable only through indirect address and data window
// - read: host writes address, later data-window read returns register
// - address register is one 32-bit word, data window 16 bits
// - autonegotiation code word sent carries bit 0 set
// - phy link results are not forwarded to pcs and mac
// - link runs at 10, 100 or 1000 mbps learned by autonegotiation
// - mac defaults to 1000 mbps operation
// - missing forwarding applies in mac role only, phy role forwards
// - status bits [3:2] report negotiated speed, 10/01/00 encoding
// - control bits 6 and 13 select pcs speed, same encoding
// - link change seen by polling status or autoneg done interrupt
// - sgmii registers reset at power-up only, not by other resets; a control bit 15 write also restores them here
// - control bit 15 resets the sgmii interface
`timescale 1ns/1ps
`default_nettype none

module sgl_sgmii_port (
  // clock and power-up reset
  input wire logic clock,
  input wire logic rst_b,
  // management register port
  input wire logic [15:0] mgmtAddr,
  input wire logic mgmtWrite,
  input wire logic mgmtRead,
  input wire logic [31:0] mgmtWdata,
  output logic [31:0] mgmtRdata,
  output logic mgmtRvalid,
  // strap: port in sgmii phy role
  input wire logic phyRole,
  // results of sgmii autonegotiation with the attached phy
  input wire logic anLinkUp,
  input wire logic [1:0] anSpeed,
  input wire logic anDuplex,
  input wire logic anDone,
  // code word sent during autonegotiation
  output logic [15:0] anCodeWord,
  // pcs and mac configuration
  output logic [1:0] macSpeed,
  output logic macDuplex,
  output logic macAnEnable,
  output logic pcsReset,
  // event to the host
  output logic autonegDoneInterrupt
);

  // ****************************************
  // management decode
  // ****************************************
  logic addrHit;
  logic dataHit;
  logic dataWrite;
  logic [31:0] indirectAddressReg;
  logic ctlSel;
  logic advSel;
  logic stsSel;
  logic addrWrite;

  assign addrHit = mgmtAddr == sgl_pkg::INDIRECT_ADDRESS_OFS;
  assign dataHit = mgmtAddr == sgl_pkg::INDIRECT_DATA_OFS;
  assign dataWrite = mgmtWrite && dataHit;
  assign addrWrite = mgmtWrite && addrHit;
  assign ctlSel = indirectAddressReg == sgl_pkg::PCS_CONTROL_ADR;
  assign advSel = indirectAddressReg == sgl_pkg::AUTONEG_ADVERTISE_ADR;
  assign stsSel = indirectAddressReg == sgl_pkg::LINK_STATUS_ADR;

  // ****************************************
  // indirect address register
  // ****************************************
  // whole 32-bit word taken at once, no partial update
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      indirectAddressReg <= sgl_pkg::INDIRECT_ADDRESS_RESET;
    end else if (addrWrite) begin
      indirectAddressReg <= mgmtWdata;
    end
  end

  // ****************************************
  // sgmii control and advertisement
  // ****************************************
  logic [15:0] pcsControl;
  logic [15:0] autonegAdvertise;
  logic interfaceReset;
  logic ctlLoad;

  // bit 15 is not stored: it self-clears by restoring both registers
  assign interfaceReset = dataWrite && ctlSel
    && mgmtWdata[sgl_pkg::CTL_RESET_BIT];
  assign ctlLoad = dataWrite && ctlSel;

  // rst_b is the power-up reset; pin and soft resets never reach here
  sgl_hold_reg #(
    .RESET_VALUE(sgl_pkg::PCS_CONTROL_RESET)
  ) controlReg (
    .clock(clock),
    .rst_b(rst_b),
    .restore(interfaceReset),
    .load(ctlLoad),
    .loadValue(mgmtWdata[15:0]),
    .value(pcsControl)
  );

  sgl_hold_reg #(
    .RESET_VALUE(sgl_pkg::AUTONEG_ADVERTISE_RESET)
  ) advertiseReg (
    .clock(clock),
    .rst_b(rst_b),
    .restore(interfaceReset),
    .load(dataWrite && advSel),
    .loadValue(mgmtWdata[15:0]),
    .value(autonegAdvertise)
  );

  // ****************************************
  // autonegotiation code word
  // ****************************************
  logic [15:0] codeWordNext;

  // bit 0 forced so the partner sees a valid word even before setup
  assign codeWordNext = autonegAdvertise | sgl_pkg::CODE_WORD_MANDATORY;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      anCodeWord <= sgl_pkg::CODE_WORD_MANDATORY;
    end else begin
      anCodeWord <= codeWordNext;
    end
  end

  // ****************************************
  // interface reset pulse
  // ****************************************
  // one cycle only: the pcs must not be held off after the restore
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pcsReset <= 1'b0;
    end else begin
      pcsReset <= interfaceReset;
    end
  end

  // ****************************************
  // autonegotiation status
  // ****************************************
  logic anDoneReg;
  logic [15:0] linkStatus;

  // set wins over the clear made by servicing the control register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      anDoneReg <= 1'b0;
    end else if (anDone) begin
      anDoneReg <= 1'b1;
    end else if (ctlLoad || interfaceReset) begin
      anDoneReg <= 1'b0;
    end
  end

  always_comb begin
    linkStatus = 16'h0000;
    linkStatus[sgl_pkg::STS_AN_DONE_BIT] = anDoneReg;
    linkStatus[sgl_pkg::STS_LINK_BIT] = anLinkUp;
    linkStatus[sgl_pkg::STS_SPEED_LSB +: 2] = anSpeed;
    linkStatus[sgl_pkg::STS_DUPLEX_BIT] = anDuplex;
  end

  assign autonegDoneInterrupt = anDoneReg;

  // ****************************************
  // pcs and mac configuration
  // ****************************************
  logic [1:0] ctlSpeed;
  logic ctlDuplex;
  logic ctlAnEnable;
  logic [1:0] speedNext;
  logic duplexNext;
  logic anEnableNext;

  assign ctlSpeed = {pcsControl[sgl_pkg::CTL_SPEED_MSB_BIT],
    pcsControl[sgl_pkg::CTL_SPEED_LSB_BIT]};
  assign ctlDuplex = pcsControl[sgl_pkg::CTL_DUPLEX_BIT];
  assign ctlAnEnable = pcsControl[sgl_pkg::CTL_AN_ENABLE_BIT];

  // mac role takes only the control register, so a mismatch with the
  // phy breaks the port until software copies the status across
  always_comb begin
    speedNext = ctlSpeed;
    duplexNext = ctlDuplex;
    anEnableNext = ctlAnEnable;
    if (phyRole) begin
      speedNext = anSpeed;
      duplexNext = anDuplex;
    end
  end

  // ****************************************
  // applied speed
  // ****************************************
  // no retrain needed: the new code is taken on the next edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      macSpeed <= sgl_pkg::SPEED_1000;
    end else begin
      macSpeed <= speedNext;
    end
  end

  // ****************************************
  // applied duplex
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      macDuplex <= 1'b1;
    end else begin
      macDuplex <= duplexNext;
    end
  end

  // ****************************************
  // applied autonegotiation enable
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      macAnEnable <= 1'b1;
    end else begin
      macAnEnable <= anEnableNext;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [15:0] windowData;
  logic [31:0] readNext;
  logic addrRead;
  logic dataRead;

  assign addrRead = mgmtRead && addrHit;
  assign dataRead = mgmtRead && dataHit;

  always_comb begin
    windowData = 16'h0000;
    if (ctlSel) begin
      windowData = pcsControl;
    end else if (advSel) begin
      windowData = autonegAdvertise;
    end else if (stsSel) begin
      windowData = linkStatus;
    end
  end

  // unmapped offsets answer zero
  always_comb begin
    readNext = 32'h00000000;
    if (addrRead) begin
      readNext = indirectAddressReg;
    end else if (dataRead) begin
      readNext = {16'h0000, windowData};
    end
  end

  // reads never alter state; data holds until the next read
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mgmtRdata <= 32'h00000000;
    end else if (mgmtRead) begin
      mgmtRdata <= readNext;
    end
  end

  // ****************************************
  // read answer strobe
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mgmtRvalid <= 1'b0;
    end else begin
      mgmtRvalid <= mgmtRead;
    end
  end

endmodule

`default_nettype wire

// file: tb/sgl_port_asserts.sv
// checker: port-level assertions for the sgmii port
`timescale 1ns/1ps
`default_nettype none

module sgl_port_asserts (
  // ports watched
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [15:0] mgmtAddr,
  input wire logic mgmtWrite,
  input wire logic mgmtRead,
  input wire logic [31:0] mgmtWdata,
  input wire logic [31:0] mgmtRdata,
  input wire logic mgmtRvalid,
  input wire logic phyRole,
  input wire logic anLinkUp,
  input wire logic [1:0] anSpeed,
  input wire logic anDuplex,
  input wire logic anDone,
  input wire logic [15:0] anCodeWord,
  input wire logic [1:0] macSpeed,
  input wire logic macDuplex,
  input wire logic macAnEnable,
  input wire logic pcsReset,
  input wire logic autonegDoneInterrupt
);
  // ****
  // properties
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire logic wr15 = mgmtWrite && mgmtWdata[15];
  wire logic offMap = mgmtAddr != 16'h7200 && mgmtAddr != 16'h7206;
  chk_read_answer: assert property (mgmtRead |=> mgmtRvalid)
    else $error("read not answered");
  chk_rdata_hold: assert property (!mgmtRvalid |-> $stable(mgmtRdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (mgmtRead && offMap |=> !mgmtRdata)
    else $error("unmapped offset read nonzero");
  chk_code_bit0: assert property (anCodeWord[0])
    else $error("code word bit 0 clear");
  chk_done_irq: assert property (anDone |=> autonegDoneInterrupt)
    else $error("interrupt missing after autoneg");
  chk_irq_sticky: assert property (
    autonegDoneInterrupt && !mgmtWrite |=> autonegDoneInterrupt)
    else $error("interrupt dropped without a write");
  // only a host write may move the mac speed in mac role
  chk_mac_kept: assert property (
    !phyRole && !$past(phyRole) && $changed(macSpeed) |->
    $past(mgmtWrite) || $past(mgmtWrite, 2) || $past(mgmtWrite, 3))
    else $error("mac speed changed without write");
  chk_phy_follow: assert property (
    (phyRole && $stable(anSpeed))[*3] |-> macSpeed == anSpeed)
    else $error("phy role speed not forwarded");
  chk_pcs_cause: assert property (
    pcsReset |-> $past(wr15) || $past(wr15, 2))
    else $error("pcs reset without bit 15 write");
  chk_pcs_pulse: assert property (pcsReset |=> !pcsReset)
    else $error("pcs reset longer than one cycle");
  cover property (anDone);
  cover property (pcsReset);
  cover property (phyRole && macSpeed == 2'h1);
endmodule

bind sgl_sgmii_port sgl_port_asserts i_chk (.clock, .rst_b, .mgmtAddr,
  .mgmtWrite, .mgmtRead, .mgmtWdata, .mgmtRdata, .mgmtRvalid, .phyRole,
  .anLinkUp, .anSpeed, .anDuplex, .anDone, .anCodeWord, .macSpeed,
  .macDuplex, .macAnEnable, .pcsReset, .autonegDoneInterrupt);

`default_nettype wire

// file: tb/sgl_phy_model.sv
// partner: attached sgmii phy negotiating a link on command
`timescale 1ns/1ps
`default_nettype none

module sgl_phy_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // command from the bench
  input wire logic go,
  input wire logic [1:0] spd,
  input wire logic dup,
  input wire logic [3:0] lag,
  // autonegotiation results
  output logic anLinkUp,
  output logic [1:0] anSpeed,
  output logic anDuplex,
  output logic anDone
);
  // ****
  // negotiation, prompt or slow by lag
  // ****
  logic [4:0] cnt;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 5'h00;
      anDone <= 1'b0;
      anLinkUp <= 1'b0;
      anSpeed <= 2'h2;
      anDuplex <= 1'b1;
    end else begin
      anDone <= cnt == 5'h01;
      if (go) begin
        cnt <= {1'b0, lag} + 5'h02;
        anLinkUp <= 1'b1;
        anSpeed <= spd;
        anDuplex <= dup;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule

`default_nettype wire

// file: tb/testbench.sv
// testbench: sgmii port register window and link configuration
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clock, rst_b, mgmtWrite, mgmtRead, mgmtRvalid, phyRole, go, dup;
  logic anLinkUp, anDuplex, anDone, macDuplex, pcsReset, irq, pcsSeen;
  logic [15:0] mgmtAddr, anCodeWord, mCtl, mAdv, mSts;
  logic [31:0] mgmtWdata, mgmtRdata, mAddr, seed;
  logic [1:0] spd, anSpeed, macSpeed;
  logic [3:0] lag;
  int n_fail, total_checks, k;
  // host value per speed code, full duplex
  logic [15:0] ctlTbl [3] = '{16'h1100, 16'h3100, 16'h1140};

  sgl_sgmii_port i_dut (.clock, .rst_b, .mgmtAddr, .mgmtWrite, .mgmtRead,
    .mgmtWdata, .mgmtRdata, .mgmtRvalid, .phyRole, .anLinkUp, .anSpeed,
    .anDuplex, .anDone, .anCodeWord, .macSpeed, .macDuplex,
    .macAnEnable(), .pcsReset, .autonegDoneInterrupt(irq));
  sgl_phy_model i_phy (.clock, .rst_b, .go, .spd, .dup, .lag, .anLinkUp,
    .anSpeed, .anDuplex, .anDone);

  always #5 clock = ~clock;
  always @(posedge clock) if (pcsReset === 1'b1) pcsSeen <= 1'b1;

  // ****
  // bench tasks
  // ****
  task automatic report_and_stop();
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] ex(input logic [15:0] a);
    if (a == 16'h7200) return mAddr;
    if (a != 16'h7206) return 32'h0;
    case (mAddr)
      32'h001F0000: return {16'h0, mCtl};
      32'h001F0004: return {16'h0, mAdv};
      32'h001F8002: return {16'h0, mSts};
      default: return 32'h0;
    endcase
  endfunction
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    mgmtAddr = a;
    mgmtWdata = d;
    mgmtWrite = 1'b1;
    @(negedge clock);
    mgmtWrite = 1'b0;
    if (a == 16'h7200) mAddr = d;
    else if (a == 16'h7206 && d[15]) {mCtl, mAdv} = {16'h1140, 16'h0};
    else if (a == 16'h7206 && mAddr == 32'h001F0000) mCtl = d[15:0];
    else if (a == 16'h7206 && mAddr == 32'h001F0004) mAdv = d[15:0];
    // idle cycle: strobe never drops and rises in one step
    @(negedge clock);
  endtask
  // masked compare: status read checks bits 4:0 only, all fields the port drives
  task automatic rd(input logic [15:0] a, input logic [31:0] m);
    mgmtAddr = a;
    mgmtRead = 1'b1;
    @(negedge clock);
    mgmtRead = 1'b0;
    chk(mgmtRvalid, 1);
    chk(mgmtRdata & m, ex(a) & m);
    @(negedge clock);
  endtask
  task automatic link(input logic [1:0] s);
    {go, spd, dup, lag} = {1'b1, s, 1'($random(seed)), 4'($random(seed))};
    @(negedge clock);
    go = 1'b0;
    mSts = {11'h0, dup, s, 2'h3};
    for (k = 0; k < 40 && irq !== 1'b1; k++) @(negedge clock);
    if (irq !== 1'b1) begin
      n_fail++;
      $display("BAD %0t no autoneg done interrupt", $time);
      report_and_stop();
    end
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    {clock, rst_b, mgmtWrite, mgmtRead, phyRole, go, spd, dup, lag} = '0;
    {mgmtAddr, mgmtWdata, mAddr, mAdv, mSts, pcsSeen} = '0;
    {n_fail, total_checks, mCtl, seed} = {64'h0, 16'h1140, 32'h5E2D9797};
    repeat (16) @(negedge clock);
    rst_b = 1'b1;
    chk(macSpeed, 2'h2);
    chk(anCodeWord, 16'h0001);
    wr(16'h7200, 32'h001F0000);
    rd(16'h7206, 32'hFFFFFFFF);
    rd(16'h7200, 32'hFFFFFFFF);
    rd(16'h7000, 32'hFFFFFFFF);
    wr(16'h7200, 32'h001F0004);
    wr(16'h7206, 32'h01A0);
    rd(16'h7206, 32'hFFFFFFFF);
    chk(anCodeWord, 16'h01A1);
    repeat (6) begin
      spd = 2'($unsigned($random(seed)) % 3);
      link(spd);
      wr(16'h7200, 32'h001F8002);
      rd(16'h7206, 32'h0000001F);
      chk(macSpeed, {mCtl[6], mCtl[13]});
      wr(16'h7200, 32'h001F0000);
      wr(16'h7206, {16'h0, ctlTbl[spd]});
      repeat (3) @(negedge clock);
      chk({macSpeed, macDuplex}, {spd, 1'b1});
      chk(irq, 0);
    end
    wr(16'h7206, 32'h9140);
    chk(pcsSeen, 1);
    rd(16'h7206, 32'hFFFFFFFF);
    wr(16'h7200, 32'h001F0004);
    rd(16'h7206, 32'hFFFFFFFF);
    phyRole = 1'b1;
    link(2'h1);
    repeat (3) @(negedge clock);
    chk(macSpeed, 2'h1);
    report_and_stop();
  end
endmodule

`default_nettype wire
